// ==== include/gdoc_defs.svh ====
// gdoc_defs.svh: offsets, field positions and reset values of the debug pin override block
// assumes: included by bare name from package and design files
`ifndef GDOC_DEFS_SVH
`define GDOC_DEFS_SVH

`define GDOC_ADDR_W 32
`define GDOC_CFG_OFFSET 32'h4000BC00
`define GDOC_STAT_OFFSET 32'h4000BC04
`define GDOC_CFG_RESET 32'h00000010
`define GDOC_STAT_RESET 32'h00000000
`define GDOC_CFG_DBGDIS_BIT 5
`define GDOC_CFG_REGEN_BIT 4
`define GDOC_CFG_RSVD_BIT 3
`define GDOC_STAT_BOOT_BIT 3
`define GDOC_STAT_FORCED_BIT 1
`define GDOC_STAT_SWEN_BIT 0

`endif

// ==== include/gdoc_pkg.sv ====
// gdoc_pkg.sv: types of the debug pin override block
// assumes: gdoc_defs.svh on the include path
`include "gdoc_defs.svh"

package gdoc_pkg;
  typedef logic [31:0] gdoc_word_t;
  typedef logic [`GDOC_ADDR_W-1:0] gdoc_addr_t;
  // boot-select capture progress after reset release
  typedef enum logic [0:0] {
    GDOC_WAIT_SAMPLE,
    GDOC_SAMPLED
  } gdoc_boot_state_t;
endpackage : gdoc_pkg

// ==== hw/gdoc_top.sv ====
// gdoc_top.sv: debug override control and status registers for the general-purpose pins
// assumes: one clock, async active-high reset, plain register port, pins from outside
`include "gdoc_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module gdoc_top (
  input wire logic clock, // 200 MHz system clock
  input wire logic rst, // async reset, active high
  input wire logic clk_en, // freezes all state while low
  input wire gdoc_pkg::gdoc_addr_t reg_addr, // register byte address
  input wire gdoc_pkg::gdoc_word_t reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output gdoc_pkg::gdoc_word_t reg_rdata, // read data, cycle after strobe
  input wire logic boot_select_pin_n, // boot-select pin, active low
  input wire logic debugger_cable_forced, // debugger cable forces debug active
  input wire logic swj_serial_wire_en, // serial wire enabled by the debug port
  input wire logic debug_request, // debug interface asks to take the pins
  input wire logic rsvd_hw_set, // hardware sets the reserved bit
  input wire logic rsvd_hw_clear, // hardware clears the reserved bit
  input wire logic regulator_enable, // regulator enable signal from power control
  output logic debug_active, // debug interface owns its pins
  output logic debug_override_permit, // debug override allowed by config
  output logic port_a_pin_seven_override, // regulator enable takes port a pin seven
  output logic port_a_pin_seven_value // level driven on port a pin seven when overridden
);

  // pin synchronisers
  logic [1:0] boot_sync_q;
  logic [1:0] forced_sync_q;
  logic [1:0] swen_sync_q;
  logic [1:0] dreq_sync_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      boot_sync_q <= 2'h3;
      forced_sync_q <= 2'h0;
      swen_sync_q <= 2'h0;
      dreq_sync_q <= 2'h0;
    end else if (clk_en) begin
      boot_sync_q <= {boot_sync_q[0], boot_select_pin_n};
      forced_sync_q <= {forced_sync_q[0], debugger_cable_forced};
      swen_sync_q <= {swen_sync_q[0], swj_serial_wire_en};
      dreq_sync_q <= {dreq_sync_q[0], debug_request};
    end
  end

  logic forced_s;
  logic swen_s;
  logic dreq_s;
  assign forced_s = forced_sync_q[1];
  assign swen_s = swen_sync_q[1];
  assign dreq_s = dreq_sync_q[1];

  // configuration register
  logic debug_override_disable_q;
  logic regulator_pin_override_enable_q;
  logic reserved_preserve_bit_q;
  logic cfg_wr;
  logic stat_hit;
  logic cfg_hit;

  assign cfg_hit = (reg_addr == `GDOC_CFG_OFFSET);
  assign stat_hit = (reg_addr == `GDOC_STAT_OFFSET);
  assign cfg_wr = reg_wr && cfg_hit;

  localparam gdoc_pkg::gdoc_word_t CFG_RST = `GDOC_CFG_RESET;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      debug_override_disable_q <= CFG_RST[`GDOC_CFG_DBGDIS_BIT];
      regulator_pin_override_enable_q <= CFG_RST[`GDOC_CFG_REGEN_BIT];
    end else if (clk_en && cfg_wr) begin
      debug_override_disable_q <= reg_wdata[`GDOC_CFG_DBGDIS_BIT];
      regulator_pin_override_enable_q <= reg_wdata[`GDOC_CFG_REGEN_BIT];
    end
  end

  // reserved bit: hardware events win over the software write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reserved_preserve_bit_q <= CFG_RST[`GDOC_CFG_RSVD_BIT];
    end else if (clk_en) begin
      if (rsvd_hw_set) begin
        reserved_preserve_bit_q <= 1'b1;
      end else if (rsvd_hw_clear) begin
        reserved_preserve_bit_q <= 1'b0;
      end else if (cfg_wr) begin
        reserved_preserve_bit_q <= reg_wdata[`GDOC_CFG_RSVD_BIT];
      end
    end
  end

  // debug ownership: once active, disable cannot revoke it
  logic debug_active_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      debug_active_q <= 1'b0;
    end else if (clk_en) begin
      if (!debug_active_q && (forced_s || (dreq_s && !debug_override_disable_q))) begin
        debug_active_q <= 1'b1;
      end
    end
  end

  assign debug_active = debug_active_q;
  assign debug_override_permit = !debug_override_disable_q;
  assign port_a_pin_seven_override = regulator_pin_override_enable_q;
  assign port_a_pin_seven_value = regulator_pin_override_enable_q & regulator_enable;

  // boot-select capture once after reset release
  gdoc_pkg::gdoc_boot_state_t boot_state_q;
  logic boot_select_sampled_q;
  logic [1:0] boot_settle_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      boot_state_q <= gdoc_pkg::GDOC_WAIT_SAMPLE;
      boot_select_sampled_q <= 1'b0;
      boot_settle_q <= 2'h0;
    end else if (clk_en) begin
      case (boot_state_q)
        gdoc_pkg::GDOC_WAIT_SAMPLE: begin
          // wait until the synchroniser holds post-reset pin values
          if (boot_settle_q == 2'h2) begin
            boot_select_sampled_q <= !boot_sync_q[1];
            boot_state_q <= gdoc_pkg::GDOC_SAMPLED;
          end else begin
            boot_settle_q <= boot_settle_q + 2'h1;
          end
        end
        gdoc_pkg::GDOC_SAMPLED: begin
          boot_state_q <= gdoc_pkg::GDOC_SAMPLED;
        end
        default: begin
          boot_state_q <= gdoc_pkg::GDOC_WAIT_SAMPLE;
        end
      endcase
    end
  end

  // status word; only listed bits, all else zero
  gdoc_pkg::gdoc_word_t stat_word;
  gdoc_pkg::gdoc_word_t cfg_word;
  always_comb begin
    stat_word = `GDOC_STAT_RESET;
    stat_word[`GDOC_STAT_BOOT_BIT] = boot_select_sampled_q;
    stat_word[`GDOC_STAT_FORCED_BIT] = forced_s;
    stat_word[`GDOC_STAT_SWEN_BIT] = swen_s;
    cfg_word = 32'h00000000;
    cfg_word[`GDOC_CFG_DBGDIS_BIT] = debug_override_disable_q;
    cfg_word[`GDOC_CFG_REGEN_BIT] = regulator_pin_override_enable_q;
    cfg_word[`GDOC_CFG_RSVD_BIT] = reserved_preserve_bit_q;
  end

  // read data register; status writes are ignored
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (clk_en) begin
      if (reg_rd && cfg_hit) begin
        reg_rdata <= cfg_word;
      end else if (reg_rd && stat_hit) begin
        reg_rdata <= stat_word;
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end
  end

  // assertions
  sequence s_cfg_write;
    clk_en && cfg_wr && !rsvd_hw_set && !rsvd_hw_clear;
  endsequence

  sequence s_no_activation_cause;
    clk_en && !debug_active_q && !forced_s && !(dreq_s && !debug_override_disable_q);
  endsequence

  sequence s_cfg_read;
    clk_en && reg_rd && cfg_hit;
  endsequence

  sequence s_stat_write;
    clk_en && reg_wr && stat_hit && !rsvd_hw_set && !rsvd_hw_clear;
  endsequence

  a_permit_follows_cfg: assert property (@(posedge clock) disable iff (rst)
    debug_override_permit == !cfg_word[`GDOC_CFG_DBGDIS_BIT])
    else $error("debug permit does not follow config bit");

  a_no_cause_idle: assert property (@(posedge clock) disable iff (rst)
    s_no_activation_cause |=> !debug_active_q)
    else $error("debug became active without a cause");

  a_forced_activates: assert property (@(posedge clock) disable iff (rst)
    (clk_en && forced_s) |=> debug_active_q)
    else $error("cable force did not activate debug");

  a_pin_value_follows: assert property (@(posedge clock) disable iff (rst)
    port_a_pin_seven_override |-> port_a_pin_seven_value == regulator_enable)
    else $error("port a pin seven value does not follow regulator");

  a_rsvd_hw_clear: assert property (@(posedge clock) disable iff (rst)
    (clk_en && rsvd_hw_clear && !rsvd_hw_set) |=> !reserved_preserve_bit_q)
    else $error("hardware clear of reserved bit lost");

  a_cfg_read: assert property (@(posedge clock) disable iff (rst)
    s_cfg_read |=> reg_rdata == $past(cfg_word))
    else $error("config read data wrong");

  a_stat_write_ignored: assert property (@(posedge clock) disable iff (rst)
    s_stat_write |=> $stable(cfg_word))
    else $error("status write changed config");

  a_stat_unused_zero: assert property (@(posedge clock) disable iff (rst)
    (stat_word & 32'hFFFFFFF4) == 32'h00000000)
    else $error("unlisted status bits not zero");

  a_cfg_unused_zero: assert property (@(posedge clock) disable iff (rst)
    (cfg_word & 32'hFFFFFFC7) == 32'h00000000)
    else $error("unlisted config bits not zero");

  a_rdata_idle_zero: assert property (@(posedge clock) disable iff (rst)
    (clk_en && !reg_rd) |=> reg_rdata == 32'h00000000)
    else $error("read data not zero outside a read");

  a_boot_hold: assert property (@(posedge clock) disable iff (rst)
    (boot_state_q == gdoc_pkg::GDOC_SAMPLED) |=> $stable(boot_select_sampled_q))
    else $error("boot select sample changed after capture");

  a_boot_before_zero: assert property (@(posedge clock) disable iff (rst)
    (boot_state_q == gdoc_pkg::GDOC_WAIT_SAMPLE) |-> !boot_select_sampled_q)
    else $error("boot select reported before capture");

  a_freeze_state: assert property (@(posedge clock) disable iff (rst)
    !clk_en |=> $stable(cfg_word) && $stable(debug_active_q) && $stable(reg_rdata))
    else $error("state changed while clock enable low");

  a_permit_reset: assert property (@(posedge clock)
    $fell(rst) |-> debug_override_permit && port_a_pin_seven_override && !debug_active_q)
    else $error("outputs not at reset values after reset");

  a_rdata_reset: assert property (@(posedge clock)
    $fell(rst) |-> reg_rdata == 32'h00000000)
    else $error("read data not zero after reset");

  a_cfg_reset_value: assert property (@(posedge clock)
    $fell(rst) |-> cfg_word == `GDOC_CFG_RESET)
    else $error("config not at reset value after reset");

  a_disable_keeps_active: assert property (@(posedge clock) disable iff (rst)
    debug_active_q |=> debug_active_q)
    else $error("active debug interface was dropped");

  a_disable_blocks_req: assert property (@(posedge clock) disable iff (rst)
    (clk_en && !debug_active_q && debug_override_disable_q && !forced_s) |=> !debug_active_q)
    else $error("debug became active while disabled");

  a_permit_takes_req: assert property (@(posedge clock) disable iff (rst)
    (clk_en && dreq_s && !debug_override_disable_q) |=> debug_active_q)
    else $error("permitted debug request not granted");

  a_regen_override: assert property (@(posedge clock) disable iff (rst)
    port_a_pin_seven_override == cfg_word[`GDOC_CFG_REGEN_BIT]
    && (!port_a_pin_seven_override -> !port_a_pin_seven_value))
    else $error("regulator pin override mismatch");

  a_rsvd_hw_wins: assert property (@(posedge clock) disable iff (rst)
    (clk_en && rsvd_hw_set) |=> reserved_preserve_bit_q)
    else $error("hardware set of reserved bit lost");

  a_cfg_write_takes: assert property (@(posedge clock) disable iff (rst)
    s_cfg_write |=> cfg_word == ($past(reg_wdata) & 32'h00000038))
    else $error("config write not stored as masked");

  a_stat_read: assert property (@(posedge clock) disable iff (rst)
    (clk_en && reg_rd && stat_hit) |=> reg_rdata == $past(stat_word))
    else $error("status read data wrong");

  a_boot_sample: assert property (@(posedge clock) disable iff (rst)
    (clk_en && boot_state_q == gdoc_pkg::GDOC_WAIT_SAMPLE && boot_settle_q == 2'h2)
    |=> boot_select_sampled_q == !$past(boot_sync_q[1]))
    else $error("boot select sample wrong");

  a_forced_status: assert property (@(posedge clock) disable iff (rst)
    stat_word[`GDOC_STAT_FORCED_BIT] == forced_sync_q[1]
    && stat_word[`GDOC_STAT_SWEN_BIT] == swen_sync_q[1])
    else $error("status bits do not follow inputs");

endmodule : gdoc_top

`default_nettype wire

// ==== tb/gdoc_far_side.sv ====
// gdoc_far_side.sv: debugger cable, debug port, boot pin and regulator outside the block
// assumes: bench sets wanted levels; pins change just after clock edges
`timescale 1ns/10ps
`default_nettype none
module gdoc_far_side (
  input wire logic clock, // system clock
  input wire logic [4:0] want, // cable, serial wire, request, boot low, regulator
  output logic cable_forced, // debugger cable forces debug
  output logic serial_wire_en, // debug port enabled serial wire
  output logic debug_req, // debug interface asks for pins
  output logic boot_pin_n, // boot-select pin, low asserted
  output logic reg_en // regulator enable
);
  initial begin
    {cable_forced, serial_wire_en, debug_req, reg_en} = 4'h0;
    boot_pin_n = 1'b1;
  end
  always @(posedge clock) begin
    cable_forced <= want[4];
    serial_wire_en <= want[3];
    debug_req <= want[2];
    boot_pin_n <= ~want[1];
    reg_en <= want[0];
  end
endmodule : gdoc_far_side
`default_nettype wire

// ==== tb/gdoc_top_tb_top.sv ====
// gdoc_top_tb_top.sv: self-checking bench of the debug pin override block
// assumes: gdoc_pkg compiled first, gdoc_defs.svh on the include path
`include "gdoc_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module gdoc_top_tb_top;
  logic clock, rst, reg_wr, reg_rd, hw_set, hw_clr, active, permit, ovr, pin_val;
  logic cf, sw, rq, bp, re, en;
  logic [4:0] want;
  gdoc_pkg::gdoc_addr_t reg_addr;
  gdoc_pkg::gdoc_word_t reg_wdata, reg_rdata, d;
  int errors, cmp_count, cycles;
  gdoc_far_side gdoc_far_side_i (.clock(clock), .want(want), .cable_forced(cf),
    .serial_wire_en(sw), .debug_req(rq), .boot_pin_n(bp), .reg_en(re));
  gdoc_top gdoc_top_i (.clock(clock), .rst(rst), .clk_en(en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .boot_select_pin_n(bp), .debugger_cable_forced(cf), .swj_serial_wire_en(sw),
    .debug_request(rq), .rsvd_hw_set(hw_set), .rsvd_hw_clear(hw_clr),
    .regulator_enable(re), .debug_active(active), .debug_override_permit(permit),
    .port_a_pin_seven_override(ovr), .port_a_pin_seven_value(pin_val));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic complete_run();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      complete_run();
    end
  end
  task automatic chk(input gdoc_pkg::gdoc_word_t seen, input gdoc_pkg::gdoc_word_t exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input gdoc_pkg::gdoc_addr_t a, input gdoc_pkg::gdoc_word_t v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input gdoc_pkg::gdoc_addr_t a, output gdoc_pkg::gdoc_word_t v);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic pulse(input logic set);
    @(posedge clock);
    if (set) hw_set <= 1'b1;
    else hw_clr <= 1'b1;
    @(posedge clock);
    {hw_set, hw_clr} <= 2'b00;
  endtask : pulse
  task automatic do_reset(input logic boot_low);
    @(posedge clock);
    want[1] <= boot_low;
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (6) @(posedge clock);
  endtask : do_reset
  task automatic t_reset();
    rd(`GDOC_CFG_OFFSET, d);
    chk(d, 32'h00000010);
    rd(`GDOC_STAT_OFFSET, d);
    chk(d, 32'h00000000);
    chk(permit, 32'h1);
    chk(ovr, 32'h1);
  endtask : t_reset
  task automatic t_fields();
    wr(`GDOC_CFG_OFFSET, 32'hFFFFFFF7);
    rd(`GDOC_CFG_OFFSET, d);
    chk(d, 32'h00000030);
    chk(permit, 32'h0);
    want[0] <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk(pin_val, 32'h1);
    wr(`GDOC_CFG_OFFSET, 32'h00000000);
    rd(`GDOC_CFG_OFFSET, d);
    chk(d, 32'h00000000);
    chk({ovr, pin_val}, 32'h0);
  endtask : t_fields
  task automatic t_rsvd();
    pulse(1'b1);
    rd(`GDOC_CFG_OFFSET, d);
    chk(d, 32'h00000008);
    wr(`GDOC_CFG_OFFSET, d | 32'h00000020);
    rd(`GDOC_CFG_OFFSET, d);
    chk(d, 32'h00000028);
    pulse(1'b0);
    rd(`GDOC_CFG_OFFSET, d);
    chk(d, 32'h00000020);
  endtask : t_rsvd
  task automatic t_debug();
    want[2] <= 1'b1;
    repeat (6) @(posedge clock);
    #1 chk(active, 32'h0);
    wr(`GDOC_CFG_OFFSET, 32'h00000000);
    repeat (4) @(posedge clock);
    #1 chk(active, 32'h1);
    wr(`GDOC_CFG_OFFSET, 32'h00000020);
    repeat (3) @(posedge clock);
    #1 chk(active, 32'h1);
    en <= 1'b0;
    wr(`GDOC_CFG_OFFSET, 32'h00000010);
    en <= 1'b1;
    rd(`GDOC_CFG_OFFSET, d);
    chk(d, 32'h00000020);
  endtask : t_debug
  task automatic t_status();
    wr(`GDOC_STAT_OFFSET, 32'hFFFFFFFF);
    rd(`GDOC_STAT_OFFSET, d);
    chk(d, 32'h00000000);
    rd(32'h4000BC08, d);
    chk(d, 32'h00000000);
    want[4:3] <= 2'b11;
    repeat (4) @(posedge clock);
    rd(`GDOC_STAT_OFFSET, d);
    chk(d, 32'h00000003);
    do_reset(1'b1);
    #1 chk(active, 32'h1);
    rd(`GDOC_STAT_OFFSET, d);
    chk(d, 32'h0000000B);
  endtask : t_status
  initial begin
    {rst, reg_wr, reg_rd, hw_set, hw_clr} = 5'h10;
    en = 1'b1;
    want = 5'h00;
    reg_addr = '0;
    reg_wdata = '0;
    do_reset(1'b0);
    t_reset();
    t_fields();
    t_rsvd();
    t_debug();
    t_status();
    complete_run();
  end
endmodule : gdoc_top_tb_top
`default_nettype wire
